// ### dv/testbench.sv
// self-checking bench for the serial eeprom target
`timescale 1ns/10ps
module testbench;
  import eeprom_pkg::*;
  localparam int         WR_CYC = 100;
  localparam logic [2:0] STRAP  = 3'h5;
  logic       clk;
  logic       sys_rst;
  logic       scl;
  logic       sda_rel;
  wire logic  sda;
  logic       sda_out;
  logic       sda_oe_n;
  logic       wp;
  logic [2:0] strap;
  logic [7:0] exp_q[$];
  int         fail_count;
  int         n_checks;
  int         polls;
  // pull-up: line is low only while someone pulls it
  assign sda = sda_rel & (sda_oe_n | sda_out);
  always #25 clk = ~clk;
  two_wire_master master (.o_scl(scl), .o_sda_rel(sda_rel), .i_sda(sda));
  serial_eeprom_read_and_write_protect #(.WR_CYC_MAX(WR_CYC)) uut (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out),
    .o_sda_oe_n(sda_oe_n), .i_write_protect(wp), .i_chip_select_strap_bit0(strap[0]),
    .i_chip_select_strap_bit1(strap[1]), .i_chip_select_strap_bit2(strap[2]));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // polls the select until acked, so a running write cycle shows as polls above one
  task automatic write_byte(input logic [12:0] a, input logic [7:0] d, input logic exp_ack, output int np);
    logic [7:0] r;
    logic       ack;
    np = 0;
    ack = 1'b1;
    while (ack === 1'b1 && np < 40) begin
      master.start();
      master.xfer({DEV_TYPE_DEF, STRAP, 1'b0}, 1'b1, r, ack);
      np++;
    end
    master.xfer({3'h7, a[12:8]}, 1'b1, r, ack);
    master.xfer(a[7:0], 1'b1, r, ack);
    master.xfer(d, 1'b1, r, ack);
    check({7'h0, ack}, {7'h0, exp_ack});
    master.stop();
  endtask
  task automatic read_seq(input logic rnd, input logic [12:0] a);
    logic [7:0] r;
    logic       ack;
    repeat (WR_CYC + 4) @(posedge clk);
    if (rnd) begin
      master.start();
      master.xfer({DEV_TYPE_DEF, STRAP, 1'b0}, 1'b1, r, ack);
      master.xfer({3'h7, a[12:8]}, 1'b1, r, ack);
      master.xfer(a[7:0], 1'b1, r, ack);
      check({7'h0, ack}, 8'h00);
    end
    master.start();
    master.xfer({DEV_TYPE_DEF, STRAP, 1'b1}, 1'b1, r, ack);
    check({7'h0, ack}, 8'h00);
    foreach (exp_q[i]) begin
      master.xfer(8'hFF, (i == exp_q.size() - 1), r, ack);
      check(r, exp_q[i]);
    end
    master.stop();
    #100;
    check({7'h0, sda_oe_n}, 8'h01);
  endtask
  task automatic wrong_select();
    logic [7:0] r;
    logic       ack;
    master.start();
    master.xfer({DEV_TYPE_DEF, ~STRAP, 1'b1}, 1'b1, r, ack);
    check({7'h0, ack}, 8'h01);
    master.start();
    master.xfer({~DEV_TYPE_DEF, STRAP, 1'b1}, 1'b1, r, ack);
    check({7'h0, ack}, 8'h01);
    master.stop();
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    fail_count++;
    end_of_test();
  end
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    wp = 1'b0;
    strap = STRAP;
    fail_count = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    exp_q = '{8'hFF, 8'hFF};
    read_seq(1'b1, 13'h0100);
    wrong_select();
    write_byte(13'h1FFF, 8'hA5, 1'b0, polls);
    check({7'h0, polls == 1}, 8'h01);
    write_byte(13'h0000, 8'h5A, 1'b0, polls);
    check({7'h0, polls > 1}, 8'h01);
    exp_q = '{8'hA5, 8'h5A};
    read_seq(1'b1, 13'h1FFF);
    exp_q = '{8'hFF};
    read_seq(1'b0, 13'h0000);
    @(negedge clk) wp = 1'b1;
    write_byte(13'h0001, 8'h00, 1'b1, polls);
    @(negedge clk) wp = 1'b0;
    read_seq(1'b1, 13'h0001);
    // after the refused write and the read's wait, a new write is acked on the first poll
    write_byte(13'h0001, 8'h77, 1'b0, polls);
    check({7'h0, polls == 1}, 8'h01);
    exp_q = '{8'h77};
    read_seq(1'b1, 13'h0001);
    end_of_test();
  end
endmodule

// ### dv/two_wire_master.sv
// behavioural two-wire bus master facing the eeprom target
`timescale 1ns/10ps
module two_wire_master (
  output logic      o_scl,
  output logic      o_sda_rel,
  input  wire logic i_sda
);
  localparam real QTR = 31.25;
  // clock stands high between frames
  initial begin
    o_scl     = 1'b1;
    o_sda_rel = 1'b1;
  end
  // data only moves while clock is low
  task automatic clk_bit(input logic b, output logic r);
    o_sda_rel = b;
    #QTR o_scl = 1'b1;
    #QTR r = i_sda;
    #QTR o_scl = 1'b0;
    #QTR;
  endtask
  task automatic start();
    o_scl = 1'b0;
    #QTR o_sda_rel = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda_rel = 1'b0;
    #QTR o_scl = 1'b0;
    #QTR;
  endtask
  task automatic stop();
    o_sda_rel = 1'b0;
    #QTR o_scl = 1'b1;
    // data held low over a full system clock with the clock high, so the stop is always seen
    #(2*QTR) o_sda_rel = 1'b1;
    #QTR;
  endtask
  // ninth bit: released when sending, driven as ack or no-ack when reading
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r[i]);
    end
    clk_bit(ack_in, ack);
  endtask
endmodule

// ### rtl/eeprom_pkg.sv
// constants shared by the serial eeprom target
package eeprom_pkg;
  localparam int         ADDR_W       = 13;
  localparam int         MEM_DEPTH    = 8192;
  localparam logic [7:0] MEM_ERASED   = 8'hFF;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] ACK_SLOT     = 4'h8;
  localparam logic [3:0] CNT_RST      = 4'h0;
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5; // arbitrary value
  localparam int         WR_TIME_MS   = 5;
  localparam int         CLK_HZ       = 20_000_000;
  localparam int         WR_CYCLES    = WR_TIME_MS * (CLK_HZ / 1000);
endpackage

// ### rtl/serial_eeprom_read_and_write_protect.sv
// two-wire serial eeprom target: select, pointer load, write protect, sequential read
// Contract
// [RULE1] write-protect high refuses every write to the array.
// [RULE2] write-protect low or open lets writes proceed normally.
// [RULE3] write-protect sampled once, on last falling clock before first data byte; code latches there the pin level from two falling clocks earlier.
// [RULE4] protected write: first data byte not acknowledged, whole request dropped.
// [RULE5] array starts as all-ones bytes.
// [RULE6] select with read bit: acknowledge, then send byte at pointer.
// [RULE7] master no-acknowledge ends read; line released, back to standby.
// [RULE8] random read starts with dummy write of select and two address bytes.
// [RULE9] repeated start plus read select sends byte at loaded address.
// [RULE10] master acknowledge after a sent byte makes the next byte follow.
// [RULE11] pointer increments after each byte, wrapping from last location to zero.
// [RULE12] answer only select matching type code and three strap inputs.
// [RULE13] ninth clock: transmitter releases data, receiver pulls low to acknowledge.
// [RULE14] no select acknowledged while internal write cycle runs.
// [RULE15] sample on rising clock, change after falling clock, open-drain drive.
// [RULE16] pointer is thirteen bits from low bits of the address bytes.
`timescale 1ns/10ps
module serial_eeprom_read_and_write_protect
  import eeprom_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE   = DEV_TYPE_DEF, // arbitrary value
  parameter int         WR_CYC_MAX = WR_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_scl,
  input  wire logic i_sda_in,
  output logic      o_sda_out,
  output logic      o_sda_oe_n,
  input  wire logic i_write_protect,
  input  wire logic i_chip_select_strap_bit0,
  input  wire logic i_chip_select_strap_bit1,
  input  wire logic i_chip_select_strap_bit2
);
  localparam int BUSY_W = $clog2(WR_CYC_MAX + 1);
  if (WR_CYC_MAX < 1) begin : g_bad_wr
    $error("write cycle count must be at least one");
  end
  typedef enum logic [2:0] {st_idle, st_dev, st_addr_hi, st_addr_lo, st_wdata, st_rstart, st_rdata} state_t;
  // link domain (serial clock)
  state_t            state;
  logic [3:0]        cnt;
  logic [6:0]        shift;
  logic [7:0]        tx;
  logic [ADDR_W-1:0] ptr;
  logic              sda_rise;
  logic              wp_lock;
  logic              wp_armed;
  logic              wr_tgl;
  logic [3:0]        pin_s1;
  logic [3:0]        pin_s2;
  logic              busy_s1;
  logic              busy_s2;
  // no reset reaches the array, so it powers up erased
  logic [7:0]        mem [MEM_DEPTH] = '{default: MEM_ERASED}; // [RULE5]

  // system domain
  logic [1:0]        line_s1;
  logic [1:0]        line_s2;
  logic              sda_d;
  logic              scl_d;
  logic              wr_s1;
  logic              wr_s2;
  logic              wr_s3;
  logic              wr_pend;
  logic [BUSY_W-1:0] busy_cnt;

  wire        start_det = sda_rise & ~i_sda_in;
  wire        stop_det  = ~sda_rise & i_sda_in;
  wire        live      = ~start_det & ~stop_det;
  wire [7:0]  rx_byte   = {shift, sda_rise};
  wire        wp_now    = pin_s2[3];
  wire [2:0]  straps    = pin_s2[2:0];
  wire        sel_match = (rx_byte[7:4] == DEV_TYPE) && (rx_byte[3:1] == straps) && !busy_s2;
  wire        at_last   = (cnt == BIT_LAST);
  wire        at_ack    = (cnt == ACK_SLOT);
  wire        mem_we    = live && (state == st_wdata) && at_last && !wp_lock; // [RULE1]
  wire [7:0]  rd_byte   = mem[ptr];
  wire [ADDR_W-1:0] ptr_inc = ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire        master_ack = ~sda_rise;
  // clock seen high on two samples, so a data bit rising just before the clock is not a stop
  wire        stop_sys  = scl_d & line_s2[1] & line_s2[0] & ~sda_d;
  wire        wr_edge   = wr_s2 ^ wr_s3;
  // open drain: only ever pulls low
  assign o_sda_out = 1'b0; // [RULE15]
  always_ff @(negedge i_scl) begin
    if (mem_we) begin
      mem[ptr] <= rx_byte; // [RULE2]
    end
  end

  always_ff @(posedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sda_rise <= 1'b1;
    end else begin
      sda_rise <= i_sda_in; // [RULE15]
    end
  end

  always_ff @(negedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_s1  <= 4'h0;
      pin_s2  <= 4'h0;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
    end else begin
      pin_s1  <= {i_write_protect, i_chip_select_strap_bit2, i_chip_select_strap_bit1, i_chip_select_strap_bit0};
      pin_s2  <= pin_s1;
      busy_s1 <= (busy_cnt != '0);
      busy_s2 <= busy_s1;
    end
  end

  // bit engine: every decision lands on a falling edge so data never moves while the clock is high
  always_ff @(negedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state      <= st_idle;
      cnt        <= CNT_RST;
      shift      <= 7'h00;
      tx         <= 8'hFF;
      ptr        <= '0;
      wp_lock    <= 1'b0;
      wp_armed   <= 1'b0;
      wr_tgl     <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else if (start_det) begin
      state      <= st_dev;
      cnt        <= CNT_RST;
      o_sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      state      <= st_idle; // [RULE7]
      o_sda_oe_n <= 1'b1;
    end else begin
      case (state)
        st_idle: begin
          o_sda_oe_n <= 1'b1;
        end
        st_rstart: begin
          o_sda_oe_n <= rd_byte[7]; // [RULE6]
          tx         <= {rd_byte[6:0], 1'b1};
          ptr        <= ptr_inc; // [RULE11]
          cnt        <= CNT_RST;
          state      <= st_rdata; // [RULE9]
        end
        st_rdata: begin
          if (at_ack) begin
            cnt <= CNT_RST;
            if (master_ack) begin
              o_sda_oe_n <= rd_byte[7]; // [RULE10]
              tx         <= {rd_byte[6:0], 1'b1};
              ptr        <= ptr_inc; // [RULE11]
            end else begin
              o_sda_oe_n <= 1'b1; // [RULE7]
              state      <= st_idle;
            end
          end else if (at_last) begin
            o_sda_oe_n <= 1'b1; // [RULE13]
            cnt        <= cnt + 4'h1;
          end else begin
            o_sda_oe_n <= tx[7];
            tx         <= {tx[6:0], 1'b1};
            cnt        <= cnt + 4'h1;
          end
        end
        default: begin
          if (at_ack) begin
            o_sda_oe_n <= 1'b1;
            cnt        <= CNT_RST;
            if (wp_armed && state == st_wdata) begin
              wp_lock  <= wp_now; // [RULE3]
              wp_armed <= 1'b0;
            end
          end else if (at_last) begin
            cnt <= cnt + 4'h1;
            case (state)
              st_dev: begin
                if (!sel_match) begin
                  state <= st_idle; // [RULE12] [RULE14]
                end else begin
                  o_sda_oe_n <= 1'b0; // [RULE13]
                  state      <= rx_byte[0] ? st_rstart : st_addr_hi;
                end
              end
              st_addr_hi: begin
                ptr[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0]; // [RULE16]
                o_sda_oe_n      <= 1'b0;
                state           <= st_addr_lo;
              end
              st_addr_lo: begin
                ptr[7:0]   <= rx_byte; // [RULE16]
                o_sda_oe_n <= 1'b0;
                wp_armed   <= 1'b1;
                state      <= st_wdata;
              end
              default: begin
                if (wp_lock) begin
                  state <= st_idle; // [RULE4]
                end else begin
                  o_sda_oe_n <= 1'b0;
                  ptr        <= ptr_inc;
                  wr_tgl     <= ~wr_tgl;
                end
              end
            endcase
          end else begin
            shift <= rx_byte[6:0];
            cnt   <= cnt + 4'h1;
          end
        end
      endcase
    end
  end

  // stop and write-cycle timing run on the system clock; stop holds long enough to be seen
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      line_s1  <= 2'h3;
      line_s2  <= 2'h3;
      sda_d    <= 1'b1;
      scl_d    <= 1'b1;
      wr_s1    <= 1'b0;
      wr_s2    <= 1'b0;
      wr_s3    <= 1'b0;
      wr_pend  <= 1'b0;
      busy_cnt <= '0;
    end else begin
      line_s1 <= {i_scl, i_sda_in};
      line_s2 <= line_s1;
      sda_d   <= line_s2[0];
      scl_d   <= line_s2[1];
      wr_s1   <= wr_tgl;
      wr_s2   <= wr_s1;
      wr_s3   <= wr_s2;
      if (stop_sys && (wr_pend || wr_edge)) begin
        busy_cnt <= BUSY_W'(WR_CYC_MAX); // [RULE14]
        wr_pend  <= 1'b0;
      end else begin
        if (wr_edge) begin
          wr_pend <= 1'b1;
        end
        if (busy_cnt != '0) begin
          busy_cnt <= busy_cnt - BUSY_W'(1);
        end
      end
    end
  end

  property p_wp_blocks;
    @(negedge i_scl) disable iff (i_sys_rst) wp_lock |-> !mem_we;
  endproperty
  a_wp_blocks: assert property (p_wp_blocks) else $error("write taken while protected"); // [RULE1]
  property p_unprot_ack;
    @(negedge i_scl) disable iff (i_sys_rst) (live && state == st_wdata && at_last && !wp_lock) |=> !o_sda_oe_n;
  endproperty
  a_unprot_ack: assert property (p_unprot_ack) else $error("unprotected data byte not acknowledged"); // [RULE2]
  property p_wp_sample;
    @(negedge i_scl) disable iff (i_sys_rst)
      (live && wp_armed && state == st_wdata && at_ack) |=> (wp_lock == $past(wp_now)) && !wp_armed;
  endproperty
  a_wp_sample: assert property (p_wp_sample) else $error("write protect not sampled"); // [RULE3]
  property p_wp_nack;
    @(negedge i_scl) disable iff (i_sys_rst)
      (live && state == st_wdata && at_last && wp_lock) |=> o_sda_oe_n && state == st_idle ##1 o_sda_oe_n;
  endproperty
  a_wp_nack: assert property (p_wp_nack) else $error("protected byte acknowledged"); // [RULE4]
  property p_ptr_wrap;
    @(negedge i_scl) disable iff (i_sys_rst)
      (mem_we || (live && state == st_rstart)) |=> ptr == ADDR_W'($past(ptr) + 1);
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not advance"); // [RULE11]
  property p_sel_miss;
    @(negedge i_scl) disable iff (i_sys_rst)
      (live && state == st_dev && at_last && !sel_match) |=> o_sda_oe_n && state == st_idle;
  endproperty
  a_sel_miss: assert property (p_sel_miss) else $error("foreign select answered"); // [RULE12]
  property p_busy_nack;
    @(negedge i_scl) disable iff (i_sys_rst) (live && busy_s2 && state == st_dev && at_last) |=> o_sda_oe_n;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("select acknowledged during write cycle"); // [RULE14]
  property p_next_byte;
    @(negedge i_scl) disable iff (i_sys_rst)
      (live && state == st_rdata && at_ack && master_ack) |=> state == st_rdata && cnt == CNT_RST;
  endproperty
  a_next_byte: assert property (p_next_byte) else $error("next byte not sent"); // [RULE10]
  property p_read_end;
    @(negedge i_scl) disable iff (i_sys_rst)
      (live && state == st_rdata && at_ack && !master_ack) |=> o_sda_oe_n && state == st_idle;
  endproperty
  a_read_end: assert property (p_read_end) else $error("read not ended on no-acknowledge"); // [RULE7]
  property p_release;
    @(negedge i_scl) disable iff (i_sys_rst) (live && state == st_rdata && at_last) |=> o_sda_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("line held in master acknowledge slot"); // [RULE13]
  c_seq_read: cover property (@(negedge i_scl) disable iff (i_sys_rst)
    state == st_rdata && at_ack && master_ack ##9 state == st_rdata && at_ack);
  c_wp_reject: cover property (@(negedge i_scl) disable iff (i_sys_rst) state == st_wdata && at_last && wp_lock);
  c_write: cover property (@(negedge i_scl) disable iff (i_sys_rst) mem_we);
  c_busy: cover property (@(posedge i_clk) disable iff (i_sys_rst) busy_cnt == BUSY_W'(1));
endmodule
